// [design/abbi_consts.vh]
// constants for the backplane bus interface
`ifndef ABBI_CONSTS_VH
`define ABBI_CONSTS_VH
`define ABBI_CLK_MHZ 250
`define ABBI_TIMEOUT_US 10
`define ABBI_TIMEOUT_CYC (`ABBI_TIMEOUT_US * `ABBI_CLK_MHZ)
// last timer count of the 10 us window at 250 MHz, sized to the timer
`define ABBI_TIMEOUT_LAST 12'h9C3
// synchronised control group: reply, four irq, dma req, sack, dc ok, ac ok
`define ABBI_CTL_W 9
`define ABBI_CTL_INIT 9'h1FC
`define ABBI_TMR_W 12
`define ABBI_DAL_W 22
`define ABBI_LOW_W 16
`define ABBI_PAR_W 2
`define ABBI_EXT_W 4
`define ABBI_IOPAGE_MSB 21
`define ABBI_IOPAGE_LSB 13
`define ABBI_IOPAGE_ALL1 9'h1FF
`define ABBI_NLEVEL 4
`define ABBI_ST_IDLE 3'h0
`define ABBI_ST_ADDR 3'h1
`define ABBI_ST_DATA 3'h2
`define ABBI_ST_DONE 3'h3
`define ABBI_ST_ERR 3'h4
`endif

// [design/abbi_sync.v]
// three flip-flop synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
module abbi_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  clk_sys,
  rstSync_n,
  din,
  dout
);
  input wire clk_sys;
  input wire rstSync_n;
  input wire [W-1:0] din;
  output reg [W-1:0] dout;
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  // ****************************************************************
  // per-bit chain, output changes when stages two and three agree
  // ****************************************************************
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
          s1_r[i] <= INIT[i];
          s2_r[i] <= INIT[i];
          s3_r[i] <= INIT[i];
          dout[i] <= INIT[i];
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            dout[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule

// [design/abbi_master.v]
// bus master and arbiter end of the asynchronous backplane bus
// How it works
// - low sixteen lines: address then data
// - lines 17:16 address, then parity
// - lines 21:18 extended address only
// - bus lines active low, power-ok high
// - abort cycle after 10 us silence
// - highest priority requester wins, keeps bus
// - arbitrate next cycle during data cycle
// - top 8 KB flagged as io page
// - master picks direction and word/byte
// - interlocked: wait for slave reply
// - processor grants bus to one device
// - power-up start, power-fail stop, io reset
// - four irq levels, ack chain, dma chain
`timescale 1ns/1ps
`include "abbi_consts.vh"
module abbi_master (
  clk_sys,
  rstn,
  reqValid,
  reqReady,
  reqAddr,
  reqWrite,
  reqByte,
  reqData,
  rspValid,
  rspData,
  rspBusErr,
  ioResetReq,
  cpuRun,
  powerFail,
  irqPending,
  irqAckReq,
  dmaGranted,
  dalIn,
  dalOut,
  dalOe,
  cycleFrame_n,
  readStrobe_n,
  writeStrobe_n,
  writeByteQual_n,
  ioPageSelect_n,
  slaveReply_n,
  ioReset_n,
  dcPowerOk,
  acPowerOk,
  intReqLevel4_n,
  intReqLevel5_n,
  intReqLevel6_n,
  intReqLevel7_n,
  intAckChainOut_n,
  dmaRequest_n,
  dmaGrantChainOut_n,
  dmaSelectAckIn_n
);
  input wire clk_sys;
  input wire rstn;
  input wire reqValid;
  output wire reqReady;
  input wire [`ABBI_DAL_W-1:0] reqAddr;
  input wire reqWrite;
  input wire reqByte;
  input wire [`ABBI_LOW_W-1:0] reqData;
  output reg rspValid;
  output reg [`ABBI_LOW_W-1:0] rspData;
  output reg rspBusErr;
  input wire ioResetReq;
  output reg cpuRun;
  output reg powerFail;
  output reg [`ABBI_NLEVEL-1:0] irqPending;
  input wire irqAckReq;
  output reg dmaGranted;
  input wire [`ABBI_DAL_W-1:0] dalIn;
  output reg [`ABBI_DAL_W-1:0] dalOut;
  output reg [`ABBI_DAL_W-1:0] dalOe;
  output reg cycleFrame_n;
  output reg readStrobe_n;
  output reg writeStrobe_n;
  output reg writeByteQual_n;
  output reg ioPageSelect_n;
  input wire slaveReply_n;
  output reg ioReset_n;
  input wire dcPowerOk;
  input wire acPowerOk;
  input wire intReqLevel4_n;
  input wire intReqLevel5_n;
  input wire intReqLevel6_n;
  input wire intReqLevel7_n;
  output reg intAckChainOut_n;
  input wire dmaRequest_n;
  output reg dmaGrantChainOut_n;
  input wire dmaSelectAckIn_n;

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rstA_r;
  reg rstB_r;
  wire rstSync_n;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstA_r <= 1'b0;
      rstB_r <= 1'b0;
    end else begin
      rstA_r <= 1'b1;
      rstB_r <= rstA_r;
    end
  end
  assign rstSync_n = rstB_r;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  wire [`ABBI_DAL_W-1:0] dalS;
  wire [`ABBI_CTL_W-1:0] ctlS;
  abbi_sync #(.W(`ABBI_DAL_W), .INIT({`ABBI_DAL_W{1'b1}})) u_syncDal (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .din(dalIn),
    .dout(dalS)
  );
  // control lines idle high, power flags start low until seen good
  abbi_sync #(.W(`ABBI_CTL_W), .INIT(`ABBI_CTL_INIT)) u_syncCtl (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .din({slaveReply_n, intReqLevel7_n, intReqLevel6_n, intReqLevel5_n,
          intReqLevel4_n, dmaRequest_n, dmaSelectAckIn_n,
          dcPowerOk, acPowerOk}),
    .dout(ctlS)
  );
  // bus controls asserted low, the two power flags asserted high
  wire replyAct = ~ctlS[8];
  wire [`ABBI_NLEVEL-1:0] irqAct = ~ctlS[7:4];
  wire dmaReqAct = ~ctlS[3];
  wire sackAct = ~ctlS[2];
  wire dcOk = ctlS[1];
  wire acOk = ctlS[0];

  // ****************************************************************
  // power sequencing and io reset
  // ****************************************************************
  // run only with both power flags good; io reset on request or dc power loss
  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cpuRun <= 1'b0;
      powerFail <= 1'b0;
      ioReset_n <= 1'b0;
      irqPending <= {`ABBI_NLEVEL{1'b0}};
    end else begin
      cpuRun <= dcOk & acOk;
      powerFail <= dcOk & ~acOk;
      ioReset_n <= ~(ioResetReq | ~dcOk);
      irqPending <= irqAct;
    end
  end

  // ****************************************************************
  // arbitration, overlapped with data cycles
  // ****************************************************************
  // interrupt ack outranks dma; a granted device keeps bus until it drops sack
  reg grantDma_r;
  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      grantDma_r <= 1'b0;
      dmaGranted <= 1'b0;
      dmaGrantChainOut_n <= 1'b1;
      intAckChainOut_n <= 1'b1;
    end else begin
      intAckChainOut_n <= ~(irqAckReq & |irqAct & ~dmaGranted);
      if (dmaGranted) begin
        dmaGranted <= sackAct;
        dmaGrantChainOut_n <= 1'b1;
      end else if (grantDma_r) begin
        dmaGrantChainOut_n <= 1'b0;
        if (sackAct) begin
          grantDma_r <= 1'b0;
          dmaGranted <= 1'b1;
          dmaGrantChainOut_n <= 1'b1;
        end else if (!dmaReqAct) begin
          grantDma_r <= 1'b0;
          dmaGrantChainOut_n <= 1'b1;
        end
      end else if (dmaReqAct && !irqAckReq) begin
        grantDma_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // data transfer state machine
  // ****************************************************************
  reg [2:0] state_r;
  reg [`ABBI_TMR_W-1:0] tmr_r;
  reg [`ABBI_DAL_W-1:0] addr_r;
  reg [`ABBI_LOW_W-1:0] wdat_r;
  reg wr_r;
  reg byte_r;
  wire isIoPage = (reqAddr[`ABBI_IOPAGE_MSB:`ABBI_IOPAGE_LSB] ==
                   `ABBI_IOPAGE_ALL1);
  // abort once the data phase has waited the whole 10 us window
  wire timeout = (tmr_r == `ABBI_TIMEOUT_LAST);
  // bus frozen while a dma device is master or power is failing
  assign reqReady = (state_r == `ABBI_ST_IDLE) & ~dmaGranted & cpuRun & ~replyAct;

  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= `ABBI_ST_IDLE;
      tmr_r <= {`ABBI_TMR_W{1'b0}};
      addr_r <= {`ABBI_DAL_W{1'b0}};
      wdat_r <= {`ABBI_LOW_W{1'b0}};
      wr_r <= 1'b0;
      byte_r <= 1'b0;
      rspValid <= 1'b0;
      rspData <= {`ABBI_LOW_W{1'b0}};
      rspBusErr <= 1'b0;
      dalOut <= {`ABBI_DAL_W{1'b1}};
      dalOe <= {`ABBI_DAL_W{1'b0}};
      cycleFrame_n <= 1'b1;
      readStrobe_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      writeByteQual_n <= 1'b1;
      ioPageSelect_n <= 1'b1;
    end else begin
      rspValid <= 1'b0;
      rspBusErr <= 1'b0;
      case (state_r)
        `ABBI_ST_IDLE: begin
          tmr_r <= {`ABBI_TMR_W{1'b0}};
          if (reqValid && reqReady) begin
            addr_r <= reqAddr;
            wdat_r <= reqData;
            wr_r <= reqWrite;
            byte_r <= reqByte;
            dalOut <= ~reqAddr;
            dalOe <= {`ABBI_DAL_W{1'b1}};
            ioPageSelect_n <= ~isIoPage;
            writeByteQual_n <= ~reqWrite;
            state_r <= `ABBI_ST_ADDR;
          end
        end
        `ABBI_ST_ADDR: begin
          // frame asserted after address settles, then data phase
          cycleFrame_n <= 1'b0;
          if (!cycleFrame_n) begin
            ioPageSelect_n <= 1'b1;
            writeByteQual_n <= ~(wr_r & byte_r);
            if (wr_r) begin
              dalOut[`ABBI_LOW_W-1:0] <= ~wdat_r;
              dalOut[`ABBI_LOW_W+`ABBI_PAR_W-1:`ABBI_LOW_W] <= {`ABBI_PAR_W{1'b1}};
              dalOe[`ABBI_LOW_W+`ABBI_PAR_W-1:0] <= {(`ABBI_LOW_W+`ABBI_PAR_W){1'b1}};
              writeStrobe_n <= 1'b0;
            end else begin
              dalOe[`ABBI_LOW_W+`ABBI_PAR_W-1:0] <= {(`ABBI_LOW_W+`ABBI_PAR_W){1'b0}};
              readStrobe_n <= 1'b0;
            end
            dalOe[`ABBI_DAL_W-1:`ABBI_LOW_W+`ABBI_PAR_W] <= {`ABBI_EXT_W{1'b0}};
            state_r <= `ABBI_ST_DATA;
          end
        end
        `ABBI_ST_DATA: begin
          tmr_r <= tmr_r + {{(`ABBI_TMR_W-1){1'b0}}, 1'b1};
          if (replyAct) begin
            if (!wr_r) begin
              rspData <= ~dalS[`ABBI_LOW_W-1:0];
            end
            readStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            state_r <= `ABBI_ST_DONE;
          end else if (timeout) begin
            readStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            state_r <= `ABBI_ST_ERR;
          end
        end
        `ABBI_ST_DONE: begin
          // wait for slave to drop reply before ending the frame
          if (!replyAct) begin
            cycleFrame_n <= 1'b1;
            writeByteQual_n <= 1'b1;
            dalOe <= {`ABBI_DAL_W{1'b0}};
            rspValid <= 1'b1;
            state_r <= `ABBI_ST_IDLE;
          end
        end
        `ABBI_ST_ERR: begin
          // strobes already off; release frame and report bus error
          cycleFrame_n <= 1'b1;
          writeByteQual_n <= 1'b1;
          dalOe <= {`ABBI_DAL_W{1'b0}};
          rspValid <= 1'b1;
          rspBusErr <= 1'b1;
          state_r <= `ABBI_ST_IDLE;
        end
        default: begin
          state_r <= `ABBI_ST_IDLE;
        end
      endcase
    end
  end
  // memory is a pure slave on the far side; nothing here initiates for it
endmodule

// [verification/abbi_master_assertions.sv]
// assertions on the bus master ports
`timescale 1ns/1ps
module abbi_master_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [21:0] reqAddr,
  input wire logic reqWrite,
  input wire logic [15:0] reqData,
  input wire logic rspValid,
  input wire logic rspBusErr,
  input wire logic dmaGranted,
  input wire logic dmaGrantChainOut_n,
  input wire logic [21:0] dalOut,
  input wire logic [21:0] dalOe,
  input wire logic cycleFrame_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic writeByteQual_n,
  input wire logic ioPageSelect_n,
  input wire logic slaveReply_n
);
  logic [11:0] toCnt_r;
  logic [15:0] wd_r;
  wire take = reqValid && reqReady;
  wire strb = !(readStrobe_n && writeStrobe_n);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles spent with a strobe asserted
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      toCnt_r <= 12'h000;
    else
      toCnt_r <= strb ? toCnt_r + 12'h001 : 12'h000;
  end
  // write data kept from the taken request
  always @(posedge clk_sys) begin
    if (take)
      wd_r <= reqData;
  end
  AST_ADDR: assert property (take |=> dalOut == ~$past(reqAddr) && &dalOe)
    else $error("address phase wrong");
  AST_FRAME: assert property (take |-> ##[1:3] !cycleFrame_n)
    else $error("frame not asserted");
  AST_IOPAGE: assert property (take |=> ioPageSelect_n == !$past(&reqAddr[21:13]))
    else $error("io page select wrong");
  AST_DIR: assert property (take |=> writeByteQual_n == !$past(reqWrite))
    else $error("direction qualifier wrong");
  AST_WDATA: assert property (!writeStrobe_n |-> dalOut[17:0] == {2'h3, ~wd_r}
    && dalOe[21:18] == 4'h0)
    else $error("write data phase wrong");
  AST_TIMEOUT: assert property (toCnt_r <= 12'h9C8)
    else $error("strobe held past timeout");
  AST_INTLK: assert property (strb && slaveReply_n && toCnt_r < 12'h960 |=> strb)
    else $error("strobe dropped without reply");
  AST_ERR: assert property (rspBusErr |-> rspValid)
    else $error("bus error without response");
  AST_END: assert property (rspValid |-> !strb)
    else $error("strobe still on at response");
  AST_DMA: assert property (dmaGranted |-> !reqReady)
    else $error("local request open while dma owns bus");
  AST_GNT: assert property (!dmaGrantChainOut_n |-> !dmaGranted)
    else $error("grant offered while a device owns the bus");
  cover property (take && reqWrite);
  cover property (rspValid && rspBusErr);
  cover property (dmaGranted);
endmodule
bind abbi_master abbi_master_chk u_abbi_master_chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .reqValid(reqValid),
  .reqReady(reqReady),
  .reqAddr(reqAddr),
  .reqWrite(reqWrite),
  .reqData(reqData),
  .rspValid(rspValid),
  .rspBusErr(rspBusErr),
  .dmaGranted(dmaGranted),
  .dmaGrantChainOut_n(dmaGrantChainOut_n),
  .dalOut(dalOut),
  .dalOe(dalOe),
  .cycleFrame_n(cycleFrame_n),
  .readStrobe_n(readStrobe_n),
  .writeStrobe_n(writeStrobe_n),
  .writeByteQual_n(writeByteQual_n),
  .ioPageSelect_n(ioPageSelect_n),
  .slaveReply_n(slaveReply_n)
);

// [verification/abbi_slave_model.sv]
// memory-like slave answering the bus master
`timescale 1ns/1ps
module abbi_slave_model (
  input wire logic clk,
  input wire logic [21:0] busLvl,
  input wire logic frame_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic wbq_n,
  input wire logic noRsp,
  input wire logic [2:0] dly,
  output logic reply_n = 1'b1,
  output logic [21:0] drv = 22'h3FFFFF,
  output logic [21:0] oe = 22'h000000
);
  logic [15:0] mem [16];
  logic [4:0] a_r;
  logic fPrev_r = 1'b1;
  logic [2:0] cnt_r = 3'h0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  // latch address at frame start, answer strobes after set delay
  always @(posedge clk) begin
    fPrev_r <= frame_n;
    if (fPrev_r && !frame_n)
      a_r <= ~busLvl[4:0];
    if (rd_n && wr_n) begin
      cnt_r <= 3'h0;
      reply_n <= 1'b1;
      oe <= 22'h000000;
    end else if (reply_n && !noRsp) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == dly) begin
        reply_n <= 1'b0;
        if (!rd_n) begin
          oe <= 22'h00FFFF;
          drv <= {6'h3F, ~mem[a_r[4:1]]};
        end else if (wbq_n)
          mem[a_r[4:1]] <= ~busLvl[15:0];
        else if (a_r[0])
          mem[a_r[4:1]][15:8] <= ~busLvl[15:8];
        else
          mem[a_r[4:1]][7:0] <= ~busLvl[7:0];
      end
    end
  end
endmodule

// [verification/abbi_master_tb_top.sv]
// self-checking bench for the bus master
`timescale 1ns/1ps
module abbi_master_tb_top;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqByte = 1'b0;
  logic [21:0] reqAddr = 22'h000000;
  logic [15:0] reqData = 16'h0000, rspData;
  logic reqReady, rspValid, rspBusErr, cpuRun, powerFail, dmaGranted;
  logic ioResetReq = 1'b0, irqAckReq = 1'b0, dcPowerOk = 1'b1, acPowerOk = 1'b1;
  logic intReqLevel4_n = 1'b1, intReqLevel5_n = 1'b1;
  logic intReqLevel6_n = 1'b1, intReqLevel7_n = 1'b1;
  logic dmaRequest_n = 1'b1, dmaSelectAckIn_n = 1'b1;
  logic [3:0] irqPending;
  logic [21:0] dalOut, dalOe, slvDrv, slvOe;
  logic cycleFrame_n, readStrobe_n, writeStrobe_n, writeByteQual_n, ioPageSelect_n;
  logic slaveReply_n, ioReset_n, intAckChainOut_n, dmaGrantChainOut_n;
  logic noRsp = 1'b0;
  logic [2:0] dly = 3'h0;
  logic [15:0] em [16];
  int num_errors = 0, comparisons = 0, cyc = 0;
  wire [21:0] dalIn = (dalOut | ~dalOe) & (slvDrv | ~slvOe);
  abbi_master u_abbi_master (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reqValid(reqValid),
    .reqReady(reqReady),
    .reqAddr(reqAddr),
    .reqWrite(reqWrite),
    .reqByte(reqByte),
    .reqData(reqData),
    .rspValid(rspValid),
    .rspData(rspData),
    .rspBusErr(rspBusErr),
    .ioResetReq(ioResetReq),
    .cpuRun(cpuRun),
    .powerFail(powerFail),
    .irqPending(irqPending),
    .irqAckReq(irqAckReq),
    .dmaGranted(dmaGranted),
    .dalIn(dalIn),
    .dalOut(dalOut),
    .dalOe(dalOe),
    .cycleFrame_n(cycleFrame_n),
    .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n),
    .writeByteQual_n(writeByteQual_n),
    .ioPageSelect_n(ioPageSelect_n),
    .slaveReply_n(slaveReply_n),
    .ioReset_n(ioReset_n),
    .dcPowerOk(dcPowerOk),
    .acPowerOk(acPowerOk),
    .intReqLevel4_n(intReqLevel4_n),
    .intReqLevel5_n(intReqLevel5_n),
    .intReqLevel6_n(intReqLevel6_n),
    .intReqLevel7_n(intReqLevel7_n),
    .intAckChainOut_n(intAckChainOut_n),
    .dmaRequest_n(dmaRequest_n),
    .dmaGrantChainOut_n(dmaGrantChainOut_n),
    .dmaSelectAckIn_n(dmaSelectAckIn_n)
  );
  abbi_slave_model u_abbi_slave_model (.clk(clk_sys), .busLvl(dalIn),
    .frame_n(cycleFrame_n), .rd_n(readStrobe_n), .wr_n(writeStrobe_n),
    .wbq_n(writeByteQual_n), .noRsp(noRsp), .dly(dly), .reply_n(slaveReply_n),
    .drv(slvDrv), .oe(slvOe));
  always #2 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task settle;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
    input logic b, input logic a0);
    if (!b)
      return d;
    return a0 ? {d[15:8], o[7:0]} : {o[15:8], d[7:0]};
  endfunction
  task xfer(input logic [21:0] a, input logic w, input logic b, input logic [15:0] d,
    input logic e);
    int i;
    i = 0;
    while (reqReady !== 1'b1 && i < 100) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    chk("reqReady", reqReady, 16'h0001);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqByte <= b;
    reqData <= d;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1;
      i++;
    end while (rspValid !== 1'b1 && i < 3000);
    chk("rspValid", rspValid, 16'h0001);
    chk("busErr", rspBusErr, e);
    if (!e && w)
      em[a[4:1]] = merge(em[a[4:1]], d, b, a[0]);
    if (!e && !w)
      chk("rdData", rspData, em[a[4:1]]);
  endtask
  // main sequence
  initial begin
    int r;
    logic w;
    r = $urandom(32'h4525AFAF);
    for (int k = 0; k < 16; k++) em[k] = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    settle();
    chk("cpuRun", cpuRun, 16'h0001);
    xfer(22'h3FE002, 1'b1, 1'b0, 16'hA5C3, 1'b0);
    xfer(22'h000003, 1'b1, 1'b1, 16'h7E00, 1'b0);
    xfer(22'h000002, 1'b0, 1'b0, 16'h0000, 1'b0);
    for (int k = 0; k < 40; k++) begin
      dly = 3'($urandom_range(7));
      w = 1'($urandom);
      xfer(22'($urandom), w, w & 1'($urandom), 16'($urandom), 1'b0);
    end
    noRsp = 1'b1;
    xfer(22'h000010, 1'b0, 1'b0, 16'h0000, 1'b1);
    noRsp = 1'b0;
    @(posedge clk_sys);
    acPowerOk <= 1'b0;
    ioResetReq <= 1'b1;
    intReqLevel5_n <= 1'b0;
    irqAckReq <= 1'b1;
    settle();
    chk("power", {powerFail, cpuRun, ioReset_n}, 16'h0004);
    chk("irq", {irqPending, intAckChainOut_n}, 16'h0004);
    @(posedge clk_sys);
    acPowerOk <= 1'b1;
    ioResetReq <= 1'b0;
    intReqLevel5_n <= 1'b1;
    irqAckReq <= 1'b0;
    dmaRequest_n <= 1'b0;
    dcPowerOk <= 1'b0;
    settle();
    chk("dmaGnt", dmaGrantChainOut_n, 16'h0000);
    chk("dcLoss", {powerFail, cpuRun, ioReset_n}, 16'h0000);
    @(posedge clk_sys);
    dmaSelectAckIn_n <= 1'b0;
    dcPowerOk <= 1'b1;
    settle();
    chk("dmaOwn", {dmaGranted, reqReady}, 16'h0002);
    @(posedge clk_sys);
    dmaRequest_n <= 1'b1;
    dmaSelectAckIn_n <= 1'b1;
    settle();
    chk("dmaEnd", {dmaGranted, reqReady}, 16'h0001);
    test_done();
  end
endmodule
